// ==== rtl/cs_top.sv ====
// Light sensor control block: serial register slave, wait timer,
// clear-channel threshold interrupt with persistence, gain, id, status.
// Assumes scl/sda from pins; measurement strobe from local sequencer.
//
// Operation
// - Wait step is 2.4 ms, or twelve times that with long-wait set.
// - Wait steps equal 256 minus the wait setting.
// - Clear result below low or above high limit flags interrupt.
// - Limits are byte pairs, low limit first, lower byte first.
// - Persistence zero interrupts after every integration cycle.
// - Codes 1-3 need that many results; 4-15 need 5 to 60.
// - Interrupt only after the required consecutive out-of-range results.
// - Long-wait flag is configuration bit 1; other bits reserved.
// - Two-bit gain field goes to the analog block.
// - Identification register returns a fixed code; writes ignored.
// - Status byte is read-only; reserved bits read as zero here.
// - Status bit 4 shows the pending interrupt.
// - Status bit 0 sets when an integration cycle completes.
// - Threshold interrupts only while enable bit 4 is set.
// - Wait timer starts only if enable bit 3 is set when a result completes.
// - Special function 00110 clears the interrupt and releases the pin.
`timescale 1ns/1ps
`include "cs_map.svh"

module cs_top #(
	parameter int STEP_CYC = `CS_WAIT_STEP_NS / `CS_CLK_NS
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// Serial bus pins
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output      logic        sda_o,
	output      logic        sda_oe_o,
	// Interrupt pin, open drain
	output      logic        int_o,
	output      logic        int_oe_o,
	// Measurement sequencer
	input  wire logic        meas_done_i,
	input  wire logic [15:0] clear_data_i,
	output      logic        wait_active_o,
	output      logic [1:0]  gain_o
);
	import cs_pkg::*;

	localparam logic [18:0] STEP_LD = 19'(STEP_CYC - 1);
	localparam logic [18:0] LONG_LD = 19'(STEP_CYC * `CS_WAIT_LONG_MUL - 1);

	cs_state_t st_r;
	cs_state_t st_nxt;
	logic      clr_evt;
	logic      out_rng;

	function automatic logic [7:0] rd_reg(input cs_state_t s,
	                                      input logic [4:0] a);
		logic [7:0] d;
		d = 8'h00;
		case (a)
			`CS_OFS_ENABLE:   d = s.enable;
			`CS_OFS_WAIT:     d = s.wait_period;
			`CS_OFS_LOW_LSB:  d = s.low[7:0];
			`CS_OFS_LOW_MSB:  d = s.low[15:8];
			`CS_OFS_HIGH_LSB: d = s.high[7:0];
			`CS_OFS_HIGH_MSB: d = s.high[15:8];
			`CS_OFS_PERSISTENCE_FILTER:     d = {4'h0, s.persistence_filter};
			`CS_OFS_CONFIG:   d[`CS_CFG_LONG_BIT] = s.long_wait_flag;
			`CS_OFS_GAIN:     d = {6'h00, s.gain_select};
			`CS_OFS_ID:       d = `CS_ID_CODE;
			`CS_OFS_STATUS: begin
				d[`CS_ST_INT_BIT]   = s.interrupt_pending_flag;
				d[`CS_ST_VALID_BIT] = s.result_valid_flag;
			end
			default:          d = 8'h00;
		endcase
		return d;
	endfunction : rd_reg

	function automatic logic [5:0] persistence_filter_need(input logic [3:0] c);
		logic [5:0] n;
		n = {2'b00, c};
		if (c > 4'h3) begin
			n = 6'(({2'b00, c} - 6'h03) * 6'h05);
		end
		return n;
	endfunction : persistence_filter_need

	always_comb begin
		logic rise;
		logic fall;
		logic start;
		logic stop;
		logic [7:0] rdat;
		logic [5:0] pinc;
		logic trig;
		st_nxt  = st_r;
		clr_evt = 1'b0;
		rdat    = 8'h00;
		pinc    = 6'h00;
		trig    = 1'b0;
		rise  = st_r.scl_s2 & ~st_r.scl_q;
		fall  = ~st_r.scl_s2 & st_r.scl_q;
		start = st_r.scl_s2 & st_r.scl_q & st_r.sda_q & ~st_r.sda_s2;
		stop  = st_r.scl_s2 & st_r.scl_q & ~st_r.sda_q & st_r.sda_s2;
		out_rng = (clear_data_i < st_r.low) || (clear_data_i > st_r.high);
		// Pin synchronisers
		st_nxt.scl_s1 = scl_i;
		st_nxt.scl_s2 = st_r.scl_s1;
		st_nxt.scl_q  = st_r.scl_s2;
		st_nxt.sda_s1 = sda_i;
		st_nxt.sda_s2 = st_r.sda_s1;
		st_nxt.sda_q  = st_r.sda_s2;

		// Serial slave
		if (start) begin
			st_nxt.ser    = CS_ADDR;
			st_nxt.bc     = 4'h0;
			st_nxt.sda_oe = 1'b0;
		end else if (stop) begin
			st_nxt.ser    = CS_IDLE;
			st_nxt.sda_oe = 1'b0;
		end else begin
			unique case (st_r.ser)
				CS_IDLE: begin
					st_nxt.sda_oe = 1'b0;
				end
				CS_ADDR, CS_WRITE: begin
					if (rise) begin
						st_nxt.sr = {st_r.sr[6:0], st_r.sda_s2};
						st_nxt.bc = st_r.bc + 4'h1;
					end else if (fall && st_r.bc == 4'h8) begin
						if (st_r.ser == CS_WRITE) begin
							st_nxt.sda_oe = 1'b1;
							st_nxt.ser    = CS_WRITE_ACK;
							if (st_r.first && st_r.sr[`CS_CMD_BIT]) begin
								st_nxt.first   = 1'b0;
								st_nxt.addr    = st_r.sr[4:0];
								st_nxt.autoinc = st_r.sr[6:5] == `CS_TYPE_AUTOINC;
								if (st_r.sr[6:5] == `CS_TYPE_SPECIAL) begin
									st_nxt.addr = st_r.addr;
									clr_evt = st_r.sr[4:0] == `CS_SF_INT_CLEAR;
								end
							end else begin
								st_nxt.first = 1'b0;
								case (st_r.addr)
									`CS_OFS_ENABLE:   st_nxt.enable = st_r.sr;
									`CS_OFS_WAIT:     st_nxt.wait_period = st_r.sr;
									`CS_OFS_LOW_LSB:  st_nxt.low[7:0] = st_r.sr;
									`CS_OFS_LOW_MSB:  st_nxt.low[15:8] = st_r.sr;
									`CS_OFS_HIGH_LSB: st_nxt.high[7:0] = st_r.sr;
									`CS_OFS_HIGH_MSB: st_nxt.high[15:8] = st_r.sr;
									`CS_OFS_PERSISTENCE_FILTER:     st_nxt.persistence_filter = st_r.sr[3:0];
									`CS_OFS_CONFIG:
										st_nxt.long_wait_flag = st_r.sr[`CS_CFG_LONG_BIT];
									`CS_OFS_GAIN:     st_nxt.gain_select = st_r.sr[1:0];
									default:          ;
								endcase
								if (st_r.autoinc) begin
									st_nxt.addr = st_r.addr + 5'h01;
								end
							end
						end else if (st_r.sr[7:1] == `CS_I2C_ADDR) begin
							st_nxt.sda_oe = 1'b1;
							st_nxt.rw     = st_r.sr[0];
							st_nxt.first  = ~st_r.sr[0];
							st_nxt.ser    = CS_ADDR_ACK;
						end else begin
							st_nxt.ser = CS_IDLE;
						end
					end
				end
				CS_ADDR_ACK, CS_WRITE_ACK, CS_READ_ACK: begin
					if (rise) begin
						st_nxt.nack = st_r.sda_s2;
					end else if (fall) begin
						st_nxt.bc     = 4'h0;
						st_nxt.sda_oe = 1'b0;
						st_nxt.ser    = CS_WRITE;
						if ((st_r.ser == CS_ADDR_ACK && st_r.rw) ||
						    (st_r.ser == CS_READ_ACK && !st_r.nack)) begin
							rdat          = rd_reg(st_r, st_r.addr);
							st_nxt.sda_oe = ~rdat[7];
							st_nxt.sr     = {rdat[6:0], 1'b0};
							st_nxt.bc     = 4'h1;
							st_nxt.ser    = CS_READ;
							if (st_r.autoinc) begin
								st_nxt.addr = st_r.addr + 5'h01;
							end
						end else if (st_r.ser == CS_READ_ACK) begin
							st_nxt.ser = CS_IDLE;
						end
					end
				end
				CS_READ: begin
					if (fall) begin
						if (st_r.bc == 4'h8) begin
							st_nxt.sda_oe = 1'b0;
							st_nxt.ser    = CS_READ_ACK;
						end else begin
							st_nxt.sda_oe = ~st_r.sr[7];
							st_nxt.sr     = {st_r.sr[6:0], 1'b0};
							st_nxt.bc     = st_r.bc + 4'h1;
						end
					end
				end
				default: begin
					st_nxt.ser = CS_IDLE;
				end
			endcase
		end

		// Wait timer after each integration
		if (st_r.wact) begin
			if (st_r.wcyc != 19'h0) begin
				st_nxt.wcyc = st_r.wcyc - 19'h1;
			end else if (st_r.wsteps == 9'h001) begin
				st_nxt.wact = 1'b0;
			end else begin
				st_nxt.wsteps = st_r.wsteps - 9'h001;
				st_nxt.wcyc   = st_r.long_wait_flag ? LONG_LD : STEP_LD;
			end
		end

		// Clear before set so a coincident event wins
		if (clr_evt) begin
			st_nxt.interrupt_pending_flag = 1'b0;
		end
		if (meas_done_i) begin
			st_nxt.result_valid_flag = 1'b1;
			st_nxt.wact = st_r.enable[`CS_EN_WAIT_BIT];
			st_nxt.wsteps = `CS_WAIT_STEPS_MAX - {1'b0, st_r.wait_period};
			st_nxt.wcyc = st_r.long_wait_flag ? LONG_LD : STEP_LD;
			pinc = (st_r.pcnt == 6'h3F) ? st_r.pcnt : st_r.pcnt + 6'h01;
			if (out_rng) begin
				st_nxt.pcnt = pinc;
				trig = pinc >= persistence_filter_need(st_r.persistence_filter);
			end else begin
				st_nxt.pcnt = 6'h00;
			end
			if (st_r.persistence_filter == 4'h0) begin
				trig = 1'b1;
			end
			if (trig && st_r.enable[`CS_EN_INT_BIT]) begin
				st_nxt.interrupt_pending_flag = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_r       <= '0;
			st_r.wait_period <= `CS_RST_WAIT;
			// Sync stages at bus idle level: no false edge after reset
			st_r.scl_s1 <= 1'b1;
			st_r.scl_s2 <= 1'b1;
			st_r.scl_q  <= 1'b1;
			st_r.sda_s1 <= 1'b1;
			st_r.sda_s2 <= 1'b1;
			st_r.sda_q  <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sda_o         = st_r.sda_out;
	assign sda_oe_o      = st_r.sda_oe;
	assign int_o         = st_r.int_out;
	assign int_oe_o      = st_r.interrupt_pending_flag;
	assign wait_active_o = st_r.wact;
	assign gain_o        = st_r.gain_select;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_out_done;
		meas_done_i && out_rng && st_r.enable[`CS_EN_INT_BIT];
	endsequence

	property p_single_out;
		s_out_done and (st_r.persistence_filter == 4'h1) |=> st_r.interrupt_pending_flag;
	endproperty
	a_single_out: assert property (p_single_out) else $error("no irq");

	property p_every_cycle;
		meas_done_i && st_r.persistence_filter == 4'h0 && st_r.enable[`CS_EN_INT_BIT]
			|=> int_oe_o;
	endproperty
	a_every_cycle: assert property (p_every_cycle) else $error("pers0");

	property p_need_five;
		(s_out_done and st_r.persistence_filter == 4'h4 && st_r.pcnt == 6'h03 &&
			!st_r.interrupt_pending_flag && !clr_evt)
			|=> !st_r.interrupt_pending_flag;
	endproperty
	a_need_five: assert property (p_need_five) else $error("early");

	property p_inrange_reset;
		meas_done_i && !out_rng |=> st_r.pcnt == 6'h00;
	endproperty
	a_inrange_reset: assert property (p_inrange_reset) else $error("pc");

	property p_enable_gate;
		$rose(st_r.interrupt_pending_flag) |->
			$past(st_r.enable[`CS_EN_INT_BIT]);
	endproperty
	a_enable_gate: assert property (p_enable_gate) else $error("gate");

	property p_hold;
		st_r.interrupt_pending_flag && !clr_evt |=> int_oe_o;
	endproperty
	a_hold: assert property (p_hold) else $error("dropped");

	property p_clear;
		clr_evt && !meas_done_i |=> !int_oe_o;
	endproperty
	a_clear: assert property (p_clear) else $error("no clear");

	property p_steps;
		meas_done_i && st_r.enable[`CS_EN_WAIT_BIT] |=>
			wait_active_o && st_r.wsteps == 9'h100 - {1'b0, $past(st_r.wait_period)};
	endproperty
	a_steps: assert property (p_steps) else $error("steps");

	property p_step_len;
		meas_done_i |=> st_r.wcyc ==
			($past(st_r.long_wait_flag) ? LONG_LD : STEP_LD);
	endproperty
	a_step_len: assert property (p_step_len) else $error("step");

	property p_no_wait;
		meas_done_i && !st_r.enable[`CS_EN_WAIT_BIT] |=> !wait_active_o;
	endproperty
	a_no_wait: assert property (p_no_wait) else $error("wait");

	property p_valid;
		meas_done_i |=> rd_reg(st_r, `CS_OFS_STATUS) ==
			{3'h0, st_r.interrupt_pending_flag, 3'h0, 1'b1};
	endproperty
	a_valid: assert property (p_valid) else $error("status");

	property p_valid_sticky;
		st_r.result_valid_flag |=> st_r.result_valid_flag;
	endproperty
	a_valid_sticky: assert property (p_valid_sticky) else $error("vld");

endmodule : cs_top

// ==== rtl/cs_map.svh ====
// Register offsets, field positions, reset values and timing counts
// of the light sensor control block. Included by the design files.
`ifndef CS_MAP_SVH
`define CS_MAP_SVH

// Register offsets (5-bit register address of the command byte)
`define CS_OFS_ENABLE      5'h00
`define CS_OFS_WAIT        5'h03
`define CS_OFS_LOW_LSB     5'h04
`define CS_OFS_LOW_MSB     5'h05
`define CS_OFS_HIGH_LSB    5'h06
`define CS_OFS_HIGH_MSB    5'h07
`define CS_OFS_PERSISTENCE_FILTER        5'h0C
`define CS_OFS_CONFIG      5'h0D
`define CS_OFS_GAIN        5'h0F
`define CS_OFS_ID          5'h12
`define CS_OFS_STATUS      5'h13

// Field positions
`define CS_EN_WAIT_BIT     3
`define CS_EN_INT_BIT      4
`define CS_CFG_LONG_BIT    1
`define CS_ST_INT_BIT      4
`define CS_ST_VALID_BIT    0
`define CS_CMD_BIT         7

// Command byte encodings
`define CS_TYPE_AUTOINC    2'h1
`define CS_TYPE_SPECIAL    2'h3
`define CS_SF_INT_CLEAR    5'h06

// Serial address and identity (identity value is arbitrary)
`define CS_I2C_ADDR        7'h2C
`define CS_ID_CODE         8'h5A

// Reset values
`define CS_RST_BYTE        8'h00
`define CS_RST_WAIT        8'hFF

// Timing
`define CS_CLK_NS          100
`define CS_WAIT_STEP_NS    2400000
`define CS_WAIT_LONG_MUL   12
`define CS_WAIT_STEPS_MAX  9'h100

`endif

// ==== rtl/cs_pkg.sv ====
// Types of the light sensor control block: serial state and full state.
// Assumes cs_map.svh for the numbers.
package cs_pkg;

	typedef enum logic [2:0] {
		CS_IDLE,
		CS_ADDR,
		CS_ADDR_ACK,
		CS_WRITE,
		CS_WRITE_ACK,
		CS_READ,
		CS_READ_ACK
	} cs_ser_t;

	typedef struct packed {
		logic        scl_s1;
		logic        scl_s2;
		logic        scl_q;
		logic        sda_s1;
		logic        sda_s2;
		logic        sda_q;
		cs_ser_t     ser;
		logic [7:0]  sr;
		logic [3:0]  bc;
		logic        rw;
		logic        first;
		logic        nack;
		logic [4:0]  addr;
		logic        autoinc;
		logic        sda_oe;
		logic        sda_out;
		logic        int_out;
		logic [7:0]  enable;
		logic [7:0]  wait_period;
		logic [15:0] low;
		logic [15:0] high;
		logic [3:0]  persistence_filter;
		logic        long_wait_flag;
		logic [1:0]  gain_select;
		logic        interrupt_pending_flag;
		logic        result_valid_flag;
		logic [5:0]  pcnt;
		logic        wact;
		logic [8:0]  wsteps;
		logic [18:0] wcyc;
	} cs_state_t;

endpackage : cs_pkg

// ==== testbench/cs_host.sv ====
// Serial host model: drives SCL and pulls SDA low, 800 ns bit cells.
// Assumes the bench resolves SDA with a pull-up and feeds it back.
`timescale 1ns/1ps
`include "cs_map.svh"

module cs_host (
	// Clock
	input  wire logic clk_i,
	// Serial pins
	input  wire logic sda_i,
	output      logic scl_o,
	output      logic sda_oe_o
);
	logic nak;

	initial begin
		scl_o    = 1'h1;
		sda_oe_o = 1'h0;
		nak      = 1'h0;
	end

	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : w

	// Data moves only while SCL is low, clear of the slave's release
	task automatic bt(input logic b, output logic r);
		w(4);
		sda_oe_o = !b;
		w(1);
		scl_o = 1'h1;
		w(2);
		r = sda_i;
		w(1);
		scl_o = 1'h0;
	endtask : bt

	task automatic st;
		w(4);
		sda_oe_o = 1'h0;
		w(1);
		scl_o = 1'h1;
		w(2);
		sda_oe_o = 1'h1;
		w(2);
		scl_o = 1'h0;
	endtask : st

	task automatic sp;
		w(4);
		sda_oe_o = 1'h1;
		w(1);
		scl_o = 1'h1;
		w(2);
		sda_oe_o = 1'h0;
		w(4);
	endtask : sp

	// One byte plus acknowledge; host NACKs the byte it reads
	task automatic xb(input logic [7:0] d, input logic rd,
			output logic [7:0] r);
		logic t;
		for (int i = 7; i >= 0; i--) begin
			bt(d[i], t);
			r[i] = t;
		end
		bt(1'h1, t);
		if (!rd)
			nak |= t;
	endtask : xb

	task automatic cmd(input logic [7:0] c);
		logic [7:0] r;
		st;
		xb({`CS_I2C_ADDR, 1'h0}, 1'h0, r);
		xb(c, 1'h0, r);
	endtask : cmd

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] r;
		cmd({3'h4, a});
		xb(d, 1'h0, r);
		sp;
	endtask : wr

	// Two bytes to successive registers via auto-increment
	task automatic wr2(input logic [4:0] a, input logic [7:0] d0,
			input logic [7:0] d1);
		logic [7:0] r;
		cmd({1'h1, `CS_TYPE_AUTOINC, a});
		xb(d0, 1'h0, r);
		xb(d1, 1'h0, r);
		sp;
	endtask : wr2

	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		logic [7:0] r;
		cmd({3'h4, a});
		st;
		xb({`CS_I2C_ADDR, 1'h1}, 1'h0, r);
		xb(8'hFF, 1'h1, d);
		sp;
	endtask : rd

	task automatic clr_int;
		cmd({1'h1, `CS_TYPE_SPECIAL, `CS_SF_INT_CLEAR});
		sp;
	endtask : clr_int

endmodule : cs_host

// ==== testbench/cs_top_tb.sv ====
// Self-checking bench of the sensor control block.
// Assumes pull-ups on SDA and the interrupt line; host is cs_host.
`timescale 1ns/1ps
`include "cs_map.svh"

module cs_top_tb;
	localparam int STEP = 4;
	logic        clk_i        = 1'h0;
	logic        sys_rst_i    = 1'h1;
	logic        meas_done_i  = 1'h0;
	logic [15:0] clear_data_i = 16'h0000;
	logic        scl, sda, h_oe, sda_o, sda_oe_o, int_o, int_oe_o;
	logic        int_n, wait_o;
	logic [1:0]  gain_o;
	logic [7:0]  rv;
	int          bad_count = 0;
	int          cmp_count = 0;
	int          n;

	always #50 clk_i = ~clk_i;
	assign sda   = !((sda_oe_o && !sda_o) || h_oe);
	assign int_n = !(int_oe_o && !int_o);

	cs_host H (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));

	cs_top #(.STEP_CYC(STEP)) DUT (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .int_o(int_o),
		.int_oe_o(int_oe_o), .meas_done_i(meas_done_i),
		.clear_data_i(clear_data_i), .wait_active_o(wait_o),
		.gain_o(gain_o)
	);

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic meas(input logic [15:0] v);
		@(posedge clk_i);
		#1;
		meas_done_i  = 1'h1;
		clear_data_i = v;
		@(posedge clk_i);
		#1;
		meas_done_i  = 1'h0;
	endtask : meas

	// Counts wait cycles after one result
	task automatic wt(input int s);
		int k;
		k = 0;
		meas(16'h0200);
		while (wait_o === 1'h1 && k < 20000) begin
			@(posedge clk_i);
			#1;
			k++;
		end
		chk(16'(k >= s * STEP && k <= s * STEP + 2), 16'h1);
	endtask : wt

	task automatic finish_test;
		$display("compares=%0d mismatches=%0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	initial begin
		#6000000;
		bad_count++;
		$display("watchdog expired");
		finish_test;
	end

	initial begin
		repeat (4) @(posedge clk_i);
		#1;
		sys_rst_i = 1'h0;
		repeat (4) @(posedge clk_i);
		#1;
		chk(16'(int_n), 16'h1);
		H.rd(`CS_OFS_WAIT, rv);
		chk(16'(rv), 16'(`CS_RST_WAIT));
		H.rd(`CS_OFS_ID, rv);
		chk(16'(rv), 16'(`CS_ID_CODE));
		H.wr(`CS_OFS_ID, 8'hA5);
		H.wr(`CS_OFS_STATUS, 8'hFF);
		H.rd(`CS_OFS_ID, rv);
		chk(16'(rv), 16'(`CS_ID_CODE));
		H.rd(`CS_OFS_STATUS, rv);
		chk(16'(rv), 16'h0000);
		H.rd(5'h1F, rv);
		chk(16'(rv), 16'h0000);
		for (int g = 0; g < 4; g++) begin
			H.wr(`CS_OFS_GAIN, 8'(g));
			chk(16'(gain_o), 16'(g));
		end
		H.wr(`CS_OFS_LOW_LSB, 8'h80);
		H.wr(`CS_OFS_LOW_MSB, 8'h01);
		H.wr(`CS_OFS_HIGH_LSB, 8'h80);
		H.wr(`CS_OFS_HIGH_MSB, 8'h02);
		H.rd(`CS_OFS_HIGH_LSB, rv);
		chk(16'(rv), 16'h0080);
		H.wr2(`CS_OFS_LOW_LSB, 8'h11, 8'h22);
		H.rd(`CS_OFS_LOW_MSB, rv);
		chk(16'(rv), 16'h0022);
		H.wr2(`CS_OFS_LOW_LSB, 8'h80, 8'h01);
		H.rd(`CS_OFS_LOW_LSB, rv);
		chk(16'(rv), 16'h0080);
		H.rd(`CS_OFS_LOW_MSB, rv);
		chk(16'(rv), 16'h0001);
		$display("register test done");

		H.wr(`CS_OFS_ENABLE, 8'h08);
		H.wr(`CS_OFS_WAIT, 8'hFE);
		wt(2);
		H.wr(`CS_OFS_WAIT, 8'h00);
		wt(256);
		H.wr(`CS_OFS_WAIT, 8'hFF);
		H.wr(`CS_OFS_CONFIG, 8'h02);
		wt(12);
		H.wr(`CS_OFS_ENABLE, 8'h00);
		wt(0);
		$display("wait test done");

		meas(16'h0000);
		chk(16'(int_n), 16'h1);
		H.wr(`CS_OFS_ENABLE, 8'h10);
		meas(16'h0200);
		chk(16'(int_n), 16'h0);
		meas(16'h0200);
		H.rd(`CS_OFS_STATUS, rv);
		chk(16'(rv), 16'h0011);
		H.clr_int();
		chk(16'(int_n), 16'h1);
		H.rd(`CS_OFS_STATUS, rv);
		chk(16'(rv), 16'h0001);
		for (int c = 1; c < 16; c++) begin
			n = (c < 4) ? c : 5 * (c - 3);
			H.wr(`CS_OFS_PERSISTENCE_FILTER, 8'(c));
			meas(16'h0180);
			H.clr_int();
			repeat (n - 1) meas(c[0] ? 16'h017F : 16'h0281);
			meas(16'h0180);
			repeat (n - 1) meas(c[0] ? 16'h017F : 16'h0281);
			chk(16'(int_n), 16'h1);
			meas(c[0] ? 16'h017F : 16'h0281);
			chk(16'(int_n), 16'h0);
		end
		chk(16'(H.nak), 16'h0);
		$display("interrupt test done");
		finish_test;
	end

endmodule : cs_top_tb
